// [io_ctl_pkg.sv]
// constants shared by the i/o transfer control block and its register slave
package io_ctl_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int BUS_W = 12;
  localparam int SEL_W = 5;
  localparam int FLAG_W = 4;
  localparam int CMD_W = 4;
  localparam int EVT_W = 4;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_REQUEST = 8'h0C;
  localparam logic [7:0] OFS_LAST_CMD = 8'h10;
  // reset values
  localparam logic [3:0] RST_CTRL_A = 4'h0;
  localparam logic [3:0] RST_MASK = 4'h0;
  // request register fields
  localparam int REQ_IRQ_BIT = 0;
  localparam int REQ_SENSE_BIT = 1;
  // status event positions
  localparam int EVT_REGA_LOAD = 0;
  localparam int EVT_INPUT_DONE = 1;
  localparam int EVT_OUTPUT_DONE = 2;
  localparam int EVT_VECTOR_ACK = 3;
  // bus field positions during the first timing cycle
  localparam int SEL_LSB = 3;
  localparam int CMD_LSB = 0;
  localparam int CMD_HI_BIT = 8;
  localparam logic [4:0] VECTOR_SELECT = 5'h00;
  // command codes: {bus bit 8, bus bits 2:0}
  localparam logic [3:0] CMD_READ_A = 4'h0;
  localparam logic [3:0] CMD_READ_B = 4'h1;
  localparam logic [3:0] CMD_WRITE_A = 4'h2;
  localparam logic [3:0] CMD_WRITE_B = 4'h3;
  localparam logic [3:0] CMD_READ_REGA = 4'h4;
  localparam logic [3:0] CMD_WRITE_REGA = 4'h5;
  localparam logic [3:0] CMD_SET_ONE = 4'h6;
  localparam logic [3:0] CMD_CLEAR_ONE = 4'h7;
  localparam logic [3:0] CMD_SET_THREE = 4'h8;
  localparam logic [3:0] CMD_CLEAR_THREE = 4'h9;
  localparam logic [3:0] CMD_SKIP = 4'hA;
  localparam int FLAG_ONE = 0;
  localparam int FLAG_THREE = 2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states, gray along idle -> armed -> active
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_ACTIVE = 2'h3
  } seq_state_type;
endpackage

// [axil_reg_slave.sv]
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [io_ctl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [io_ctl_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [io_ctl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [io_ctl_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_en,
  output logic [io_ctl_pkg::ADDR_W-1:0] wr_addr,
  output logic [io_ctl_pkg::DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [io_ctl_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [io_ctl_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_ok
);
  import io_ctl_pkg::*;

  logic rd_pend_reg;

  // address and data are taken independently, then one write strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      wr_en <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        wready <= 1'b0;
      end
      wr_en <= !awready && !wready && !bvalid && !wr_en;
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rd_pend_reg <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      rd_addr <= '0;
    end else begin
      if (arvalid && arready) begin
        rd_addr <= araddr;
        arready <= 1'b0;
        rd_pend_reg <= 1'b1;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_ok ? rd_data : '0;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [io_transfer_control_outputs.sv]
// i/o transfer control: flags, transfer codes, gating strobes, skip/irq, priority chain
// Contract
// - gate and command timing taken from device-select strobe; transfer code and vector ack from first timing cycle
// - user outputs follow control register a
// - write-control-a command reloads all four outputs
// - set/clear commands for outputs one, three
// - transfer code decoded during first timing cycle
// - code: vector 00, reads 01, else 11
// - transfer code outputs are pull-low only
// - input gates place peripheral data on bus
// - output gates latch bus into peripheral
// - skip line low for irq or sense
// - skip/irq output is pull-low only
// - priority out high only with no request
// - respond only when bus select bits match
`timescale 1ns/1ps
`default_nettype none
module io_transfer_control_outputs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [io_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [io_ctl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [io_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [io_ctl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // processor timing
  input wire logic device_select_strobe_n,
  input wire logic transfer_direction_timing,
  input wire logic first_io_timing_cycle,
  input wire logic [io_ctl_pkg::SEL_W-1:0] select_straps,
  // shared data bus, two-way
  input wire logic [io_ctl_pkg::BUS_W-1:0] shared_data_bus_in,
  output logic [io_ctl_pkg::BUS_W-1:0] shared_data_bus_out,
  output logic shared_data_bus_oe,
  // user outputs
  output logic [io_ctl_pkg::FLAG_W-1:0] user_output_lines,
  // transfer code, open drain
  output logic transfer_code_bit_one_out,
  output logic transfer_code_bit_one_oe,
  output logic transfer_code_bit_two_out,
  output logic transfer_code_bit_two_oe,
  // peripheral gating strobes, active high
  output logic peripheral_input_gate_a,
  output logic peripheral_input_gate_b,
  output logic peripheral_output_gate_a,
  output logic peripheral_output_gate_b,
  // skip/irq, open drain, and priority chain
  output logic skip_or_irq_line_out,
  output logic skip_or_irq_line_oe,
  input wire logic priority_chain_in,
  output logic priority_chain_out
);
  import io_ctl_pkg::*;

  logic wr_en, wr_ok, rd_ok, sw_wr;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  logic [FLAG_W-1:0] control_register_a_reg;
  logic [FLAG_W-1:0] control_register_a_next;
  logic [EVT_W-1:0] status_reg, mask_reg, event_pulse;
  logic irq_request_reg, sense_flag_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic cmd_valid_reg;
  logic [BUS_W-1:0] bus_hold_reg;
  seq_state_type state_reg, state_next;

  logic selected, vector_ack, read_kind, in_pulse, pulse_end;
  logic [CMD_W-1:0] cmd_in;

  axil_reg_slave axil_reg_slave_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
    .araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
    .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
  );

  // decode of the first timing cycle
  assign cmd_in = {shared_data_bus_in[CMD_HI_BIT], shared_data_bus_in[CMD_LSB +: 3]};
  assign selected = first_io_timing_cycle &&
    (shared_data_bus_in[SEL_LSB +: SEL_W] == select_straps);
  // a pending request answers the vector address only while priority reaches it
  assign vector_ack = first_io_timing_cycle && irq_request_reg && priority_chain_in &&
    (shared_data_bus_in[SEL_LSB +: SEL_W] == VECTOR_SELECT);
  assign read_kind = (cmd_in == CMD_READ_A) || (cmd_in == CMD_READ_B) ||
    (cmd_in == CMD_READ_REGA);
  // strobe pulse of an accepted command
  assign in_pulse = (state_reg != ST_IDLE) && !device_select_strobe_n;
  assign pulse_end = (state_reg == ST_ACTIVE) && device_select_strobe_n;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (selected) state_next = ST_ARMED;
      end
      ST_ARMED: begin
        if (!device_select_strobe_n) state_next = ST_ACTIVE;
        else if (first_io_timing_cycle && !selected) state_next = ST_IDLE;
      end
      ST_ACTIVE: begin
        if (device_select_strobe_n) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 4'h0;
      cmd_valid_reg <= 1'b0;
      bus_hold_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && selected) begin
        cmd_reg <= cmd_in;
      end
      cmd_valid_reg <= (state_next != ST_IDLE);
      // bus may be gone once the strobe rises, so keep the last value seen
      if (in_pulse) bus_hold_reg <= shared_data_bus_in;
    end
  end

  // control register a: processor commands beat a same-cycle software write
  always_comb begin
    control_register_a_next = control_register_a_reg;
    if (sw_wr && wr_addr == OFS_CTRL_A) control_register_a_next = wr_data[FLAG_W-1:0];
    if (pulse_end && !transfer_direction_timing && cmd_reg == CMD_WRITE_REGA) begin
      control_register_a_next = bus_hold_reg[FLAG_W-1:0];
    end
    if (pulse_end) begin
      case (cmd_reg)
        CMD_SET_ONE: control_register_a_next[FLAG_ONE] = 1'b1;
        CMD_CLEAR_ONE: control_register_a_next[FLAG_ONE] = 1'b0;
        CMD_SET_THREE: control_register_a_next[FLAG_THREE] = 1'b1;
        CMD_CLEAR_THREE: control_register_a_next[FLAG_THREE] = 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_register_a_reg <= RST_CTRL_A;
      user_output_lines <= RST_CTRL_A;
    end else begin
      control_register_a_reg <= control_register_a_next;
      user_output_lines <= control_register_a_next;
    end
  end

  // transfer code outputs only ever pull low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transfer_code_bit_one_out <= 1'b0;
      transfer_code_bit_two_out <= 1'b0;
      transfer_code_bit_one_oe <= 1'b0;
      transfer_code_bit_two_oe <= 1'b0;
    end else begin
      transfer_code_bit_one_out <= 1'b0;
      transfer_code_bit_two_out <= 1'b0;
      transfer_code_bit_one_oe <= vector_ack || (selected && read_kind);
      transfer_code_bit_two_oe <= vector_ack;
    end
  end

  // gates follow the strobe, one cycle late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peripheral_input_gate_a <= 1'b0;
      peripheral_input_gate_b <= 1'b0;
      peripheral_output_gate_a <= 1'b0;
      peripheral_output_gate_b <= 1'b0;
      shared_data_bus_out <= 12'h000;
      shared_data_bus_oe <= 1'b0;
    end else begin
      peripheral_input_gate_a <= in_pulse && transfer_direction_timing &&
        cmd_reg == CMD_READ_A;
      peripheral_input_gate_b <= in_pulse && transfer_direction_timing &&
        cmd_reg == CMD_READ_B;
      peripheral_output_gate_a <= in_pulse && !transfer_direction_timing &&
        cmd_reg == CMD_WRITE_A;
      peripheral_output_gate_b <= in_pulse && !transfer_direction_timing &&
        cmd_reg == CMD_WRITE_B;
      // only register a contents are ever driven by this block
      shared_data_bus_oe <= in_pulse && transfer_direction_timing && cmd_reg == CMD_READ_REGA;
      shared_data_bus_out <= {{(BUS_W-FLAG_W){1'b0}}, control_register_a_reg};
    end
  end

  // skip/irq pulls low; priority stops at a pending request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_or_irq_line_out <= 1'b0;
      skip_or_irq_line_oe <= 1'b0;
      priority_chain_out <= 1'b0;
    end else begin
      skip_or_irq_line_out <= 1'b0;
      skip_or_irq_line_oe <= irq_request_reg ||
        (in_pulse && cmd_reg == CMD_SKIP && sense_flag_reg);
      priority_chain_out <= priority_chain_in && !irq_request_reg;
    end
  end

  // software registers and interrupt status
  assign sw_wr = wr_en && wr_strb[0] && wr_ok;
  assign event_pulse[EVT_REGA_LOAD] = pulse_end && !transfer_direction_timing &&
    cmd_reg == CMD_WRITE_REGA;
  assign event_pulse[EVT_INPUT_DONE] = pulse_end &&
    (cmd_reg == CMD_READ_A || cmd_reg == CMD_READ_B);
  assign event_pulse[EVT_OUTPUT_DONE] = pulse_end &&
    (cmd_reg == CMD_WRITE_A || cmd_reg == CMD_WRITE_B);
  assign event_pulse[EVT_VECTOR_ACK] = vector_ack;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 4'h0;
      mask_reg <= RST_MASK;
      irq_request_reg <= 1'b0;
      sense_flag_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      // new events win over a write-one-to-clear in the same cycle
      status_reg <= (status_reg & ~((sw_wr && wr_addr == OFS_STATUS) ?
        wr_data[EVT_W-1:0] : 4'h0)) | event_pulse;
      if (sw_wr && wr_addr == OFS_MASK) mask_reg <= wr_data[EVT_W-1:0];
      if (sw_wr && wr_addr == OFS_REQUEST) begin
        irq_request_reg <= wr_data[REQ_IRQ_BIT];
        sense_flag_reg <= wr_data[REQ_SENSE_BIT];
      end
      // acknowledge drops the request unless software raises it again
      if (vector_ack && !(sw_wr && wr_addr == OFS_REQUEST && wr_data[REQ_IRQ_BIT])) begin
        irq_request_reg <= 1'b0;
      end
      irq <= |(status_reg & mask_reg);
    end
  end

  assign wr_ok = (wr_addr == OFS_CTRL_A) || (wr_addr == OFS_STATUS) ||
    (wr_addr == OFS_MASK) || (wr_addr == OFS_REQUEST);
  assign rd_ok = (rd_addr == OFS_CTRL_A) || (rd_addr == OFS_STATUS) ||
    (rd_addr == OFS_MASK) || (rd_addr == OFS_REQUEST) || (rd_addr == OFS_LAST_CMD);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      OFS_CTRL_A: rd_data[FLAG_W-1:0] = control_register_a_reg;
      OFS_STATUS: rd_data[EVT_W-1:0] = status_reg;
      OFS_MASK: rd_data[EVT_W-1:0] = mask_reg;
      OFS_REQUEST: rd_data[1:0] = {sense_flag_reg, irq_request_reg};
      OFS_LAST_CMD: rd_data[CMD_W:0] = {cmd_valid_reg, cmd_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // checks
  a_gate_outside_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(device_select_strobe_n) |-> !peripheral_input_gate_a && !peripheral_input_gate_b &&
    !peripheral_output_gate_a && !peripheral_output_gate_b)
    else $error("gating strobe active outside strobe pulse");
  a_input_gate_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    (peripheral_input_gate_a || peripheral_input_gate_b) |-> $past(transfer_direction_timing))
    else $error("input gate without read direction");
  a_output_gate_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    (peripheral_output_gate_a || peripheral_output_gate_b) |->
    !$past(transfer_direction_timing))
    else $error("output gate without write direction");
  a_flags_soft_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (sw_wr && wr_addr == OFS_CTRL_A && !pulse_end) |=>
    user_output_lines == $past(wr_data[FLAG_W-1:0]))
    else $error("user outputs miss a register a write");
  a_rega_write_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (pulse_end && !transfer_direction_timing && cmd_reg == CMD_WRITE_REGA) |=>
    user_output_lines == $past(bus_hold_reg[FLAG_W-1:0]))
    else $error("register a write not loaded");
  a_set_one_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (pulse_end && cmd_reg == CMD_SET_ONE && !(sw_wr && wr_addr == OFS_CTRL_A)) |=>
    control_register_a_reg == ($past(control_register_a_reg) | 4'h1))
    else $error("set output one disturbed other bits");
  a_code_read_kind: assert property (@(posedge aclk) disable iff (!aresetn)
    (selected && read_kind && !vector_ack) |=>
    transfer_code_bit_one_oe && !transfer_code_bit_two_oe)
    else $error("read transfer code wrong");
  a_code_open_drain: assert property (@(posedge aclk) disable iff (!aresetn)
    !transfer_code_bit_one_out && !transfer_code_bit_two_out && !skip_or_irq_line_out)
    else $error("open drain output driving high");
  a_code_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(first_io_timing_cycle) |-> !transfer_code_bit_one_oe && !transfer_code_bit_two_oe)
    else $error("transfer code outside first timing cycle");
  a_irq_pulls_low: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_request_reg ##1 irq_request_reg |-> skip_or_irq_line_oe)
    else $error("pending request not on skip line");
  a_priority_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    priority_chain_out |-> $past(priority_chain_in) && !$past(irq_request_reg))
    else $error("priority passed with request pending");
  a_select_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_IDLE && first_io_timing_cycle && !selected) |=> state_reg == ST_IDLE)
    else $error("unselected device armed");
endmodule
`default_nettype wire

// [proc_model.sv]
// processor model issuing i/o transfer instructions over the timing strobes
`timescale 1ns/1ps
`default_nettype none
module proc_model (
  // clock
  input wire logic aclk,
  // processor timing
  output logic strobe_n,
  output logic dir,
  output logic first,
  output logic [11:0] bus_in,
  // device side of the bus and lines
  input wire logic [11:0] bus_out,
  input wire logic bus_oe,
  input wire logic [3:0] gates,
  input wire logic code_one_oe,
  input wire logic code_two_oe,
  input wire logic skip_oe
);
  logic [11:0] cpu_bus;
  // wired bus: the device wins only while it drives
  assign bus_in = bus_oe ? bus_out : cpu_bus;
  initial begin
    strobe_n = 1'b1;
    dir = 1'b1;
    first = 1'b0;
    cpu_bus = 12'h000;
  end
  // transfer code lines read through the pull-up as the inverse of the enables; skip records the skip/irq enable itself
  task automatic io_instr(input logic [4:0] sel, input logic [3:0] cmd, input logic rd,
    input logic [11:0] d, output logic [1:0] code, output logic [4:0] seen,
    output logic skip, output logic [11:0] got);
    seen = 5'h00;
    skip = 1'b0;
    got = 12'h000;
    @(posedge aclk);
    first <= 1'b1;
    cpu_bus <= {3'h0, cmd[3], sel, cmd[2:0]};
    @(posedge aclk);
    first <= 1'b0;
    strobe_n <= 1'b0;
    dir <= rd;
    // on a read the cpu lets go: inverse of the last value, never a stale copy
    cpu_bus <= rd ? ~cpu_bus : d;
    // code stands only for the one cycle after the first timing cycle
    #1;
    code = {~code_one_oe, ~code_two_oe};
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      #1;
      seen = seen | {bus_oe, gates};
      skip = skip | skip_oe;
      if (bus_oe) got = bus_out;
    end
    @(posedge aclk);
    strobe_n <= 1'b1;
    @(posedge aclk);
    cpu_bus <= ~cpu_bus;
  endtask
endmodule
`default_nettype wire

// [io_transfer_control_outputs_tb.sv]
// testbench: register bus and processor instructions against the i/o control block
`timescale 1ns/1ps
`default_nettype none
module io_transfer_control_outputs_tb;
  import io_ctl_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq, awready, wready, bvalid;
  logic arready, rvalid, strobe_n, dir, first, prio_in, prio_out, bus_oe, c1o, c1e, c2o, c2e;
  logic ia, ib, oa, ob, sko, ske, skip, rdc;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, flags, e, m;
  logic [1:0] bresp, rresp, code;
  logic [4:0] straps, seen;
  logic [11:0] bus_in, bus_out, got;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  io_transfer_control_outputs io_transfer_control_outputs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .device_select_strobe_n(strobe_n), .transfer_direction_timing(dir),
    .first_io_timing_cycle(first), .select_straps(straps), .shared_data_bus_in(bus_in),
    .shared_data_bus_out(bus_out), .shared_data_bus_oe(bus_oe), .user_output_lines(flags),
    .transfer_code_bit_one_out(c1o), .transfer_code_bit_one_oe(c1e),
    .transfer_code_bit_two_out(c2o), .transfer_code_bit_two_oe(c2e),
    .peripheral_input_gate_a(ia), .peripheral_input_gate_b(ib),
    .peripheral_output_gate_a(oa), .peripheral_output_gate_b(ob),
    .skip_or_irq_line_out(sko), .skip_or_irq_line_oe(ske),
    .priority_chain_in(prio_in), .priority_chain_out(prio_out));
  proc_model proc_model_inst (.aclk(aclk), .strobe_n(strobe_n), .dir(dir), .first(first),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .gates({ob, oa, ib, ia}),
    .code_one_oe(c1e), .code_two_oe(c2e), .skip_oe(ske));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic stop_test;
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string s);
    checked++;
    if (g !== x) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, s, g, x);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // master waits on the answer itself; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, x, "bresp");
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, x, "rdata");
    chk(rresp, xr, "rresp");
  endtask
  task automatic run(input logic [4:0] s, input logic [3:0] c, input logic r,
    input logic [11:0] d);
    proc_model_inst.io_instr(s, c, r, d, code, seen, skip, got);
    tick(2);
    chk({ia, ib, oa, ob}, 4'h0, "gates idle");
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    straps = 5'h15;
    prio_in = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    chk(flags, 4'h0, "reset flags");
    rdr(OFS_CTRL_A, 32'h0, RESP_OKAY);
    wr(OFS_CTRL_A, 32'h6, RESP_OKAY);
    tick(1);
    chk(flags, 4'h6, "flags follow reg");
    wr(8'h14, 32'h1, RESP_SLVERR);
    rdr(8'h14, 32'h0, RESP_SLVERR);
    run(straps, CMD_WRITE_REGA, 1'b0, 12'hFFA);
    tick(1);
    chk(flags, 4'hA, "write cmd");
    chk(code, 2'h3, "code other");
    e = 4'hA;
    // set/clear must leave the neighbouring flags alone
    for (int i = 0; i < 4; i++) begin
      m = (i < 2) ? 4'h1 : 4'h4;
      e = i[0] ? (e & ~m) : (e | m);
      run(straps, 4'(CMD_SET_ONE + i), 1'b0, 12'hFF0);
      tick(1);
      chk(flags, e, "set clear");
    end
    for (int i = 0; i < 5; i++) begin
      rdc = (i != 2 && i != 3);
      run(straps, 4'(i), rdc, 12'h3C5);
      chk(seen, 32'h1 << i, "gate select");
      chk(code, rdc ? 2'h1 : 2'h3, "code read");
    end
    chk(got, 12'h00A, "reg a on bus");
    run(~straps, CMD_WRITE_A, 1'b0, 12'h000);
    chk(seen, 5'h00, "no match");
    wr(OFS_STATUS, 32'hF, RESP_OKAY);
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    run(straps, CMD_WRITE_A, 1'b0, 12'h123);
    tick(2);
    chk(irq, 1'b0, "irq masked");
    rdr(OFS_STATUS, 32'h4, RESP_OKAY);
    wr(OFS_MASK, 32'h4, RESP_OKAY);
    tick(2);
    chk(irq, 1'b1, "irq raised");
    wr(OFS_STATUS, 32'h4, RESP_OKAY);
    tick(2);
    chk(irq, 1'b0, "irq cleared");
    wr(OFS_REQUEST, 32'h2, RESP_OKAY);
    run(straps, CMD_SKIP, 1'b1, 12'h000);
    chk(skip, 1'b1, "skip sense set");
    wr(OFS_REQUEST, 32'h0, RESP_OKAY);
    run(straps, CMD_SKIP, 1'b1, 12'h000);
    chk(skip, 1'b0, "skip sense clear");
    rdr(OFS_LAST_CMD, {28'h0, CMD_SKIP}, RESP_OKAY);
    wr(OFS_REQUEST, 32'h1, RESP_OKAY);
    tick(2);
    chk(ske, 1'b1, "irq pulls low");
    chk({sko, c1o, c2o}, 3'h0, "pull low only");
    chk(prio_out, 1'b0, "prio own req");
    run(VECTOR_SELECT, 4'h0, 1'b1, 12'h000);
    chk(code, 2'h0, "code vector");
    rdr(OFS_REQUEST, 32'h0, RESP_OKAY);
    rdr(OFS_STATUS, 32'h8, RESP_OKAY);
    tick(2);
    chk(prio_out, 1'b1, "prio free");
    @(posedge aclk);
    prio_in <= 1'b0;
    tick(2);
    chk(prio_out, 1'b0, "prio upstream");
    stop_test();
  end
endmodule
`default_nettype wire
